// *** pihs_pkg.sv ***
// Package for the host interrupt status and mask block: register map, field layout, carriers.
// Assumes a single 100 MHz register clock shared by every user of these definitions.
`default_nettype none
package pihs_pkg;
	localparam int unsigned PIHS_DATA_W = 32;
	localparam int unsigned PIHS_ADDR_W = 4;
	// Register byte offsets
	localparam logic [PIHS_ADDR_W-1:0] PIHS_OFS_STAT_SET = 4'h0;
	localparam logic [PIHS_ADDR_W-1:0] PIHS_OFS_STAT_CLR = 4'h4;
	localparam logic [PIHS_ADDR_W-1:0] PIHS_OFS_EN_SET = 4'h8;
	localparam logic [PIHS_ADDR_W-1:0] PIHS_OFS_EN_CLR = 4'hc;
	// Field positions
	localparam int unsigned PIHS_SOFT_LO = 24;
	localparam int unsigned PIHS_SOFT_W = 4;
	localparam int unsigned PIHS_BIT_PARITY = 6;
	localparam int unsigned PIHS_BIT_SYSERR = 5;
	localparam int unsigned PIHS_BIT_INIT_ABORT = 2;
	localparam int unsigned PIHS_BIT_RESP_ABORT = 1;
	// Implemented bits; all others read as zero
	localparam logic [PIHS_DATA_W-1:0] PIHS_IMPL_MASK = 32'h0f00_0066;
	localparam logic [PIHS_DATA_W-1:0] PIHS_RST_ZERO = 32'h0000_0000;
	// Power state codes
	localparam logic [1:0] PIHS_PWR_D0 = 2'h0;
	localparam logic [1:0] PIHS_PWR_RST = 2'h0;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [PIHS_ADDR_W-1:0] addr;
		logic [PIHS_DATA_W-1:0] wdata;
	} pihs_req_s;

	typedef struct packed {
		logic parity_error_seen;
		logic system_error_seen;
		logic initiator_abort_seen;
		logic responder_abort_seen;
	} pihs_evt_s;

	typedef struct packed {
		logic [PIHS_DATA_W-1:0] status;
		logic [PIHS_DATA_W-1:0] enable;
		logic [1:0] pwr;
		logic [PIHS_DATA_W-1:0] rdata;
		logic rvalid;
		logic host_irq_out_n;
	} pihs_state_s;
endpackage : pihs_pkg
`default_nettype wire

// *** pihs_host_irq.sv ***
// Host interrupt status, enable set/clear and active-low host interrupt for the PCI target.
// Assumes register requests, error events and power state come from logic on ref_clk.
// Overview of operation
// - Writing 1 to status clear bits 27-24 clears matching software interrupt status.
// - Writing 1 to status clear bit 6 clears parity error seen.
// - Writing 1 to status clear bit 5 clears system error seen.
// - Writing 1 to status clear bit 2 clears initiator abort seen.
// - Writing 1 to status clear bit 1 clears responder abort seen.
// - Enable register changes only through enable set and enable clear writes.
// - Interrupt output low while any status and enable pair is set in D0.
// - Interrupt output held high in power states D1, D2 and D3.
// - Enable set write sets each enable bit written with 1.
// - Enable clear write clears each enable bit written with 1.
// - Enable set read returns the enable register.
// - Enable clear read returns status AND enable.
// - Enables reset to 0; reserved bits read-only and read 0.
// - Host reaches these registers indirectly through base address registers.
// - Status clear read returns current status bits in their positions.
// - Status set write of 1 sets that status bit.
`default_nettype none
module pihs_host_irq
	import pihs_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Register port reached through base address windows
	input wire pihs_req_s req,
	output logic [PIHS_DATA_W-1:0] rdata,
	output logic rvalid,
	// Error events and power state
	input wire pihs_evt_s evt,
	input wire logic [1:0] pwr_state,
	// Host interrupt
	output logic host_irq_out_n
);
	pihs_state_s st;
	pihs_state_s next_st;
	logic [PIHS_DATA_W-1:0] evt_vec;
	logic wr_stat_set;
	logic wr_stat_clr;
	logic wr_en_set;
	logic wr_en_clr;

	always_comb begin
		evt_vec = PIHS_RST_ZERO;
		evt_vec[PIHS_BIT_PARITY] = evt.parity_error_seen;
		evt_vec[PIHS_BIT_SYSERR] = evt.system_error_seen;
		evt_vec[PIHS_BIT_INIT_ABORT] = evt.initiator_abort_seen;
		evt_vec[PIHS_BIT_RESP_ABORT] = evt.responder_abort_seen;
	end

	// Address decode of the base address window
	assign wr_stat_set = req.wr && (req.addr == PIHS_OFS_STAT_SET);
	assign wr_stat_clr = req.wr && (req.addr == PIHS_OFS_STAT_CLR);
	assign wr_en_set = req.wr && (req.addr == PIHS_OFS_EN_SET);
	assign wr_en_clr = req.wr && (req.addr == PIHS_OFS_EN_CLR);

	always_comb begin
		next_st = st;
		next_st.pwr = pwr_state;
		// Status: clear first, then software and hardware sets win
		if (wr_stat_clr) begin
			next_st.status = st.status & ~req.wdata;
		end
		if (wr_stat_set) begin
			next_st.status = next_st.status | req.wdata;
		end
		next_st.status = (next_st.status | evt_vec) & PIHS_IMPL_MASK;
		// Enable only through set and clear aliases
		if (wr_en_set) begin
			next_st.enable = (st.enable | req.wdata) & PIHS_IMPL_MASK;
		end else if (wr_en_clr) begin
			next_st.enable = st.enable & ~req.wdata;
		end
		// Read return, one cycle later
		next_st.rvalid = req.rd;
		next_st.rdata = PIHS_RST_ZERO;
		if (req.rd) begin
			unique case (req.addr)
				PIHS_OFS_STAT_SET, PIHS_OFS_STAT_CLR: next_st.rdata = st.status;
				PIHS_OFS_EN_SET: next_st.rdata = st.enable;
				PIHS_OFS_EN_CLR: next_st.rdata = st.status & st.enable;
				default: next_st.rdata = PIHS_RST_ZERO;
			endcase
		end
		// Level interrupt, gated by power state
		next_st.host_irq_out_n = !((|(next_st.status & next_st.enable)) && (pwr_state == PIHS_PWR_D0));
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st.status <= PIHS_RST_ZERO;
			st.enable <= PIHS_RST_ZERO;
			st.pwr <= PIHS_PWR_RST;
			st.rdata <= PIHS_RST_ZERO;
			st.rvalid <= 1'b0;
			st.host_irq_out_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign rdata = st.rdata;
	assign rvalid = st.rvalid;
	assign host_irq_out_n = st.host_irq_out_n;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	sequence s_rd_en_set;
		req.rd && req.addr == PIHS_OFS_EN_SET;
	endsequence
	sequence s_rd_en_clr;
		req.rd && req.addr == PIHS_OFS_EN_CLR;
	endsequence
	sequence s_rd_stat;
		req.rd && req.addr == PIHS_OFS_STAT_CLR;
	endsequence

	a_soft_clear_done: assert property (wr_stat_clr && !wr_stat_set |=>
		(st.status[PIHS_SOFT_LO +: PIHS_SOFT_W] & $past(req.wdata[PIHS_SOFT_LO +: PIHS_SOFT_W])) == '0)
		else $error("Software status bit survived a clear");
	a_parity_clear: assert property (wr_stat_clr && req.wdata[PIHS_BIT_PARITY] && !wr_stat_set
		&& !evt.parity_error_seen |=> !st.status[PIHS_BIT_PARITY])
		else $error("Parity status not cleared");
	a_syserr_clear: assert property (wr_stat_clr && req.wdata[PIHS_BIT_SYSERR] && !wr_stat_set
		&& !evt.system_error_seen |=> !st.status[PIHS_BIT_SYSERR])
		else $error("System error status not cleared");
	a_init_abort_clear: assert property (wr_stat_clr && req.wdata[PIHS_BIT_INIT_ABORT] && !wr_stat_set
		&& !evt.initiator_abort_seen |=> !st.status[PIHS_BIT_INIT_ABORT])
		else $error("Initiator abort status not cleared");
	a_resp_abort_clear: assert property (wr_stat_clr && req.wdata[PIHS_BIT_RESP_ABORT] && !wr_stat_set
		&& !evt.responder_abort_seen |=> !st.status[PIHS_BIT_RESP_ABORT])
		else $error("Responder abort status not cleared");
	a_enable_hold: assert property (!wr_en_set && !wr_en_clr |=> $stable(st.enable))
		else $error("Enable changed without a set or clear write");
	a_irq_level: assert property ((|(st.status & st.enable)) && st.pwr == PIHS_PWR_D0 |-> !host_irq_out_n)
		else $error("Interrupt not asserted for enabled status in D0");
	a_irq_power_off: assert property (st.pwr != PIHS_PWR_D0 |-> host_irq_out_n)
		else $error("Interrupt asserted outside D0");
	a_enable_set: assert property (wr_en_set |=> (($past(req.wdata) & PIHS_IMPL_MASK) & ~st.enable) == '0)
		else $error("Enable set write missed a bit");
	a_enable_clear: assert property (wr_en_clr |=> ($past(req.wdata) & st.enable) == '0)
		else $error("Enable clear write missed a bit");
	a_read_enable: assert property (s_rd_en_set ##1 rvalid |-> rdata == $past(st.enable))
		else $error("Enable set read returned wrong data");
	a_read_masked: assert property (s_rd_en_clr ##1 rvalid |-> rdata == ($past(st.status) & $past(st.enable)))
		else $error("Masked status read wrong");
	a_reserved_zero: assert property (((st.enable | st.status | rdata) & ~PIHS_IMPL_MASK) == '0)
		else $error("Reserved bit reads nonzero");
	a_read_status: assert property (s_rd_stat ##1 rvalid |-> rdata == $past(st.status))
		else $error("Status read wrong");
	a_status_set: assert property (wr_stat_set |=> (($past(req.wdata) & PIHS_IMPL_MASK) & ~st.status) == '0)
		else $error("Status set write missed a bit");
	a_set_wins: assert property (evt.parity_error_seen |=> st.status[PIHS_BIT_PARITY])
		else $error("Hardware event lost against a clear");
endmodule : pihs_host_irq
`default_nettype wire

// *** pihs_host.sv ***
// Host model: issues one register access per clock toward the interrupt block.
// Assumes the caller enters access at a falling edge of ref_clk, once per cycle.
`default_nettype none
module pihs_host
	import pihs_pkg::*;
(
	// Clock
	input wire logic ref_clk,
	// Register port
	output var pihs_req_s req,
	input wire logic [PIHS_DATA_W-1:0] rdata,
	input wire logic rvalid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial req = '0;
	task automatic access(input logic wr, input logic rd, input logic [PIHS_ADDR_W-1:0] addr,
		input logic [PIHS_DATA_W-1:0] wdata, output logic [PIHS_DATA_W-1:0] got, output logic gv);
		req = '{wr: wr, rd: rd, addr: addr, wdata: wdata & 32'h7fff_ffff};
		@(posedge ref_clk);
		@(negedge ref_clk);
		got = rdata;
		gv = rvalid;
	endtask : access
endmodule : pihs_host
`default_nettype wire

// *** pihs_host_interrupt_status_mask_bench.sv ***
// Bench: random register traffic, events and power states checked against a reference model.
// Assumes pihs_pkg, pihs_host_irq and pihs_host are compiled first.
`default_nettype none
module pihs_host_interrupt_status_mask_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import pihs_pkg::*;
	logic ref_clk, nrst, rvalid, host_irq_out_n, gv;
	pihs_req_s req;
	pihs_evt_s evt;
	logic [1:0] pwr_state;
	logic [31:0] rdata, stat, en, exp_rd, got;
	logic [3:0] a;
	logic [3:0] addrs [5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h2};
	integer err_total = 0, cmp_count = 0, seed = 83414, cyc = 0, i, r;
	pihs_host_irq dut(.ref_clk(ref_clk), .nrst(nrst), .req(req), .rdata(rdata), .rvalid(rvalid),
		.evt(evt), .pwr_state(pwr_state), .host_irq_out_n(host_irq_out_n));
	pihs_host host(.ref_clk(ref_clk), .req(req), .rdata(rdata), .rvalid(rvalid));
	task automatic chk_data(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_data
	task automatic chk_irq(input logic e);
		cmp_count++;
		if (host_irq_out_n !== e) begin
			err_total++;
			$display("Error host_irq_out_n expected %b seen %b", e, host_irq_out_n);
		end
	endtask : chk_irq
	task automatic results();
		$display("Checks %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : results
	task automatic step(input logic wr, input logic rd, input logic [3:0] ad, input logic [31:0] d);
		logic [31:0] ev;
		logic [31:0] dm;
		evt = (($random(seed) & 3) == 0) ? 4'($random(seed)) : 4'h0;
		pwr_state = (($random(seed) & 3) == 0) ? 2'($random(seed)) : PIHS_PWR_D0;
		ev = {25'h0, evt.parity_error_seen, evt.system_error_seen, 2'h0, evt.initiator_abort_seen,
			evt.responder_abort_seen, 1'b0};
		dm = d & PIHS_IMPL_MASK;
		exp_rd = (ad == PIHS_OFS_STAT_SET || ad == PIHS_OFS_STAT_CLR) ? stat :
			(ad == PIHS_OFS_EN_SET) ? en : (ad == PIHS_OFS_EN_CLR) ? (stat & en) : 32'h0;
		host.access(wr, rd, ad, d, got, gv);
		if (wr) begin
			case (ad)
				PIHS_OFS_STAT_SET: stat = stat | dm;
				PIHS_OFS_STAT_CLR: stat = stat & ~dm;
				PIHS_OFS_EN_SET: en = en | dm;
				PIHS_OFS_EN_CLR: en = en & ~dm;
				default: en = en;
			endcase
		end
		stat = stat | ev;
		if (rd) chk_data("read data", exp_rd, got);
		chk_data("read valid", {31'h0, rd}, {31'h0, gv});
		chk_irq((pwr_state == PIHS_PWR_D0 && (stat & en) != 0) ? 1'b0 : 1'b1);
	endtask : step
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			results();
		end
	end
	initial begin
		nrst = 1'b0;
		evt = '0;
		pwr_state = PIHS_PWR_D0;
		stat = 32'h0;
		en = 32'h0;
		repeat (2) @(negedge ref_clk);
		nrst = 1'b1;
		step(1'b0, 1'b1, PIHS_OFS_EN_SET, 32'h0);
		for (i = 0; i < 1500; i++) begin
			a = addrs[{$random(seed)} % 5];
			r = $random(seed);
			if (host_irq_out_n === 1'b0 && r[4]) begin
				step(1'b0, 1'b1, PIHS_OFS_EN_CLR, 32'h0);
			end else begin
				step(r[0], !r[0] && r[1], a, $random(seed));
			end
		end
		results();
	end
endmodule : pihs_host_interrupt_status_mask_bench
`default_nettype wire
